// File: rtl/io_port.sv
// eight-pin bidirectional i/o port with external interrupt latches
// How it works
// - eight pins, bit x controls pin x
// - input pin: data read returns sampled pin
// - latch write on input leaves pin alone
// - input option: 0 floating, 1 pull-up
// - dir/opt: 00 float,01 pull,10 od,11 pp
// - output pin: latch drives, read returns latch
// - output option selects push-pull or open-drain
// - pull-up input raises request on its vector
// - edge sense programmable per vector
// - up to seven vectors, pins share vectors
// - shared pins combined before edge detect
// - vector fetch clears its request latch
// - changing edge sense clears those requests
// - request reaches cpu only when unmasked
// - peripheral output overrides pin, level readable on input pins
// - input with alt output reads alt value
// - output with alt input gets latch value
// - low power keeps config, interrupts wake
//
// The register offsets and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
`include "io_port_map.svh"
module io_port #(
  parameter int NVEC = 7
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // pads: input, output, output enable, pull-up
  input wire logic [7:0] pin_in,
  output io_port_pkg::pad_drive_s pad,
  // alternate functions
  input wire io_port_pkg::alt_ctrl_s alt,
  output logic [7:0] alt_in,
  // interrupt side of the cpu
  input wire logic [23:0] vec_map,
  input wire logic global_mask,
  input wire logic [NVEC-1:0] vec_fetch,
  input wire logic low_power,
  output logic [NVEC-1:0] ext_irq,
  output logic wake
);
  // register state
  // one bit per pin in data, direction, option and irq registers; one bit per vector in edge and request
  logic [7:0] data_r;      // port_data_latch
  logic [7:0] dir_r;       // pin_direction
  logic [7:0] opt_r;       // pin_option
  logic [7:0] edge_r;      // edge_sense_control, 1 = rising
  logic [7:0] irqcap_r;    // pins able to raise interrupts
  logic [NVEC-1:0] pend_r; // request latches
  logic [7:0] s1_r, s2_r, s3_r; // three-stage pin sampler
  logic [7:0] pin_sync;    // agreed pin level
  logic [NVEC-1:0] comb_prev_r;
  logic [NVEC-1:0] comb_now;
  logic [NVEC-1:0] edge_hit;
  logic [7:0] rd_data;
  logic [7:0] eff_oe, eff_val, irq_pin;
  logic acc, wr, hit;

  // vector number of pin i from the 3-bit map field
  function automatic logic [2:0] vec_of(input logic [23:0] m, input int i);
    vec_of = m[i*3 +: 3];
  endfunction

  // a request is taken while ack is low; ack blocks a second take
  assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // a write lands at the edge where ack is high, the same edge at
  // which the master samples ack; the request still stands then
  assign wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
  assign hit = (wb_adr_i <= `OFS_IRQCFG);

  // pin synchroniser stages
  // pins are asynchronous; three stages keep metastability out
  // of the level filter and of the edge detectors
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_r <= 8'h00;
      s2_r <= 8'h00;
      s3_r <= 8'h00;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // level counts only once two late stages agree
  // a pin that glitches for a single cycle never reaches
  // the data reads or the interrupt edge detectors
  logic [7:0] lvl_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lvl_r <= 8'h00;
    end else begin
      lvl_r <= (s2_r & s3_r) | (lvl_r & (s2_r | s3_r));
    end
  end
  assign pin_sync = lvl_r;

  // configuration registers, single-cycle ack slave
  // the status index is read-only, so writes to it are dropped;
  // unmapped indices get an error held until the request drops and never reach here
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      data_r <= `RST_DATA;
      dir_r <= `RST_DIR;
      opt_r <= `RST_OPT;
      edge_r <= `RST_EDGE;
      irqcap_r <= `RST_IRQCFG;
    end else if (wr) begin
      unique case (wb_adr_i)
        `OFS_DATA: data_r <= wb_dat_i[7:0];
        `OFS_DIR: dir_r <= wb_dat_i[7:0];
        `OFS_OPT: opt_r <= wb_dat_i[7:0];
        `OFS_EDGE: edge_r <= wb_dat_i[7:0];
        `OFS_IRQCFG: irqcap_r <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  // ack dropped the cycle after; error held until the request drops
  // read data is captured at the taking edge and stands with ack;
  // trade-off: one cycle of latency for a clean registered bus
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= acc & hit;
      wb_err_o <= acc & ~hit;
      wb_dat_o <= {24'h00_0000, rd_data};
    end
  end

  // pin drive decode
  // pads follow the registers combinationally, so a direction
  // change reaches the pin in the cycle after the write lands
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      eff_oe[i] = alt.out_en[i] | dir_r[i];
      eff_val[i] = alt.out_en[i] ? alt.out_val[i] : data_r[i];
      pad.oe[i] = alt.out_en[i] | (dir_r[i] & (opt_r[i] | ~data_r[i]));
      pad.out[i] = eff_val[i];
      // pull-up only on input with option
      pad.pull[i] = ~eff_oe[i] & opt_r[i];
      // interrupt input: pull-up mode on capable pin
      irq_pin[i] = ~eff_oe[i] & opt_r[i] & irqcap_r[i];
      // peripheral input sees latch on outputs
      alt_in[i] = dir_r[i] ? data_r[i] : pin_sync[i];
    end
  end

  // register read mux
  // input pins show the synchronised level, so a data read
  // lags a pin change by four clock cycles
  always_comb begin
    rd_data = 8'h00;
    unique case (wb_adr_i)
      `OFS_DATA: begin
        for (int i = 0; i < 8; i++) begin
          // input with alt output shows alt value
          if (alt.out_en[i] & ~dir_r[i])
            rd_data[i] = alt.out_val[i];
          else if (dir_r[i])
            rd_data[i] = data_r[i];
          else
            rd_data[i] = pin_sync[i];
        end
      end
      `OFS_DIR: rd_data = dir_r;
      `OFS_OPT: rd_data = opt_r;
      `OFS_EDGE: rd_data = edge_r;
      `OFS_STATUS: rd_data = {{(8-NVEC){1'b0}}, pend_r};
      `OFS_IRQCFG: rd_data = irqcap_r;
      default: rd_data = 8'h00;
    endcase
  end

  // combine shared pins, low masks the others
  // a vector idles high; pins not enabled leave it high, so only
  // an enabled pin held low can hide its neighbours' edges
  always_comb begin
    for (int v = 0; v < NVEC; v++) begin
      comb_now[v] = 1'b1;
      for (int i = 0; i < 8; i++) begin
        if (irq_pin[i] && vec_of(vec_map, i) == 3'(v))
          comb_now[v] = comb_now[v] & pin_sync[i];
      end
      edge_hit[v] = edge_r[v] ? (comb_now[v] & ~comb_prev_r[v]) : (~comb_now[v] & comb_prev_r[v]);
    end
  end

  // previous combined level
  // reset to the idle level so that no false edge follows reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) comb_prev_r <= '1;
    else comb_prev_r <= comb_now;
  end

  // request latches, set wins over fetch clear
  // a sense change beats a new edge; a new edge beats a fetch,
  // so an event landing in the fetch cycle is never lost
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pend_r <= '0;
    end else begin
      for (int v = 0; v < NVEC; v++) begin
        if (wr && wb_adr_i == `OFS_EDGE && wb_dat_i[v] != edge_r[v])
          pend_r[v] <= 1'b0;
        else if (edge_hit[v])
          pend_r[v] <= 1'b1;
        else if (vec_fetch[v])
          pend_r[v] <= 1'b0;
      end
    end
  end

  assign ext_irq = global_mask ? '0 : pend_r;
  // wake from low power, state untouched
  // limitation: wake ignores the global mask, which gates ext_irq only, also in low power
  assign wake = low_power & (|pend_r);

  // masked means silent
  // the mask gates ext_irq only, pending state is kept
  a_irq_masked: assert property (@(posedge clock) disable iff (rst)
    global_mask |-> ext_irq == '0) else $error("irq while masked");

  // fetch clears request
  // only checked when no edge or write competes in that cycle
  a_fetch_clear: assert property (@(posedge clock) disable iff (rst)
    vec_fetch[0] && !edge_hit[0] && !wr |=> !pend_r[0]) else $error("fetch did not clear");

  // edge sets request
  // a detected edge must never be dropped outside write cycles
  a_edge_set: assert property (@(posedge clock) disable iff (rst)
    edge_hit[0] && !wr |=> pend_r[0]) else $error("edge lost");

  // sense change clears
  // vector 1 stands for all vectors here
  a_sense_clear: assert property (@(posedge clock) disable iff (rst)
    wr && wb_adr_i == `OFS_EDGE && wb_dat_i[1] != edge_r[1] |=> !pend_r[1]) else $error("sense not cleared");

  // open-drain floats high
  // a driven one here would fight the outside pull-up
  a_od_float: assert property (@(posedge clock) disable iff (rst)
    dir_r[0] && !opt_r[0] && data_r[0] && !alt.out_en[0] |-> !pad.oe[0]) else $error("od drives high");

  // peripheral takes pin
  // the peripheral overrides direction, option and latch
  a_alt_take: assert property (@(posedge clock) disable iff (rst)
    alt.out_en[2] |-> pad.oe[2] && pad.out[2] == alt.out_val[2]) else $error("alt not driving");

  // input read shows pin
  // read data is the level seen at the taking edge
  a_input_read: assert property (@(posedge clock) disable iff (rst)
    acc && !wb_we_i && wb_adr_i == `OFS_DATA && !dir_r[3] && !alt.out_en[3] |=> wb_dat_o[3] == $past(pin_sync[3]))
    else $error("input read wrong");

  // pull-up follows option
  // inputs only; outputs never enable the pull-up
  a_pull_input: assert property (@(posedge clock) disable iff (rst)
    !dir_r[4] && !alt.out_en[4] |-> pad.pull[4] == opt_r[4]) else $error("pull wrong");

  // agreed high propagates
  // two agreeing stages must reach the level one edge later
  a_sync_delay: assert property (@(posedge clock) disable iff (rst)
    (s2_r[5] && s3_r[5]) |=> pin_sync[5]) else $error("sync wrong");

  // push-pull drives latch
  // pin 1 stands in for all; the decode loop is uniform
  a_pp_drive: assert property (@(posedge clock) disable iff (rst)
    dir_r[1] && opt_r[1] && !alt.out_en[1] |-> pad.oe[1] && pad.out[1] == data_r[1]) else $error("pp drive wrong");

  // open-drain pulls low
  // a zero is driven in both output modes
  a_od_low: assert property (@(posedge clock) disable iff (rst)
    dir_r[6] && !opt_r[6] && !data_r[6] && !alt.out_en[6] |-> pad.oe[6] && !pad.out[6]) else $error("od not low");

  // input never driven
  // a latch write on an input pin must leave the pad released
  a_input_hiz: assert property (@(posedge clock) disable iff (rst)
    !dir_r[6] && !alt.out_en[6] |-> !pad.oe[6]) else $error("input driven");

  // output read shows latch
  // the stored value, not the pin, comes back on outputs
  a_output_read: assert property (@(posedge clock) disable iff (rst)
    acc && !wb_we_i && wb_adr_i == `OFS_DATA && dir_r[3] |=> wb_dat_o[3] == $past(data_r[3]))
    else $error("output read wrong");

  // input reads alt value
  // peripheral output wins over the pin level on inputs
  a_alt_read: assert property (@(posedge clock) disable iff (rst)
    acc && !wb_we_i && wb_adr_i == `OFS_DATA && !dir_r[4] && alt.out_en[4] |=> wb_dat_o[4] == $past(alt.out_val[4]))
    else $error("alt read wrong");

  // peripheral sees latch
  // on outputs the peripheral input ignores the pad
  a_alt_input: assert property (@(posedge clock) disable iff (rst)
    dir_r[1] |-> alt_in[1] == data_r[1]) else $error("alt input wrong");

  // sense change wins
  // even an edge in the same cycle must not leave a request
  a_sense_wins: assert property (@(posedge clock) disable iff (rst)
    wr && wb_adr_i == `OFS_EDGE && wb_dat_i[0] != edge_r[0] |=> !pend_r[0]) else $error("sense lost race");

  // pending request wakes
  // any pending vector must end low power
  a_wake_req: assert property (@(posedge clock) disable iff (rst)
    low_power && pend_r != '0 |-> wake) else $error("no wake");

  // no wake when running
  // wake is only meaningful during low power
  a_no_wake: assert property (@(posedge clock) disable iff (rst)
    !low_power |-> !wake) else $error("wake while running");

  // unmasked requests pass
  // with the mask clear every pending vector is visible
  a_unmask_pass: assert property (@(posedge clock) disable iff (rst)
    !global_mask |-> ext_irq == pend_r) else $error("irq not passed");

  // floating input released
  // neither pull-up nor drive on a floating input
  a_float_input: assert property (@(posedge clock) disable iff (rst)
    !dir_r[5] && !opt_r[5] && !alt.out_en[5] |-> !pad.pull[5] && !pad.oe[5]) else $error("float wrong");

  // ack lasts one cycle
  // a longer ack would let a held request be taken twice
  a_ack_single: assert property (@(posedge clock) disable iff (rst)
    wb_ack_o |=> !wb_ack_o) else $error("ack too long");

  // unmapped index refused
  // an error, held while the request stands, and no ack for indices past the map
  a_err_refuse: assert property (@(posedge clock) disable iff (rst)
    acc && wb_adr_i > `OFS_IRQCFG |=> wb_err_o && !wb_ack_o) else $error("unmapped acked");

  // low pin masks vector
  // one enabled pin held low keeps its vector low
  a_combine_mask: assert property (@(posedge clock) disable iff (rst)
    irq_pin[1] && vec_of(vec_map, 1) == 3'h1 && !pin_sync[1] |-> !comb_now[1]) else $error("mask lost");

  // agreed low propagates
  // two agreeing low stages must clear the level
  a_sync_hold: assert property (@(posedge clock) disable iff (rst)
    !s2_r[5] && !s3_r[5] |=> !pin_sync[5]) else $error("sync low wrong");

  // interrupt input pulled up
  // interrupt inputs are the pull-up input mode
  a_pull_irq: assert property (@(posedge clock) disable iff (rst)
    irq_pin[0] |-> pad.pull[0]) else $error("irq pin not pulled");

  // request held until fetch
  // nothing but a fetch or a sense write may drop a request
  a_pend_hold: assert property (@(posedge clock) disable iff (rst)
    pend_r[0] && !vec_fetch[0] && !wr |=> pend_r[0]) else $error("request dropped");

  // latch write stores value
  // the data write must land whole in the latch
  a_write_lands: assert property (@(posedge clock) disable iff (rst)
    wr && wb_adr_i == `OFS_DATA |=> data_r == $past(wb_dat_i[7:0])) else $error("write lost");
endmodule

// File: rtl/io_port_map.svh
// register offsets and reset values of the i/o port
`ifndef IO_PORT_MAP_SVH
`define IO_PORT_MAP_SVH
`define OFS_DATA 4'h0
`define OFS_DIR 4'h1
`define OFS_OPT 4'h2
`define OFS_EDGE 4'h3
`define OFS_STATUS 4'h4
`define OFS_IRQCFG 4'h5
`define RST_DATA 8'hFF
`define RST_DIR 8'h00
`define RST_OPT 8'h00
`define RST_EDGE 8'h00
`define RST_IRQCFG 8'h01
`endif

// File: rtl/io_port_pkg.sv
// types shared by the i/o port
package io_port_pkg;
  // pin drive group: output value, output enable, pull-up enable
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull;
  } pad_drive_s;
  // alternate function group from the peripherals
  typedef struct packed {
    logic [7:0] out_en;
    logic [7:0] out_val;
    logic [7:0] in_en;
  } alt_ctrl_s;
endpackage

// File: dv/pin_model.sv
// pin model: outside drivers, pull-ups and floating pads
`timescale 1ns/1ps
module pin_model (
  // clock
  input wire logic clock,
  // pad side of the port
  input wire io_port_pkg::pad_drive_s pad,
  // outside driver
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_in
);
  // undriven lines wander, so a stale value never passes
  logic [7:0] flt_r = 8'h55;
  always_ff @(posedge clock) flt_r <= ~flt_r;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_in[i] = pad.oe[i] ? pad.out[i] : ext_en[i] ? ext_val[i] : pad.pull[i] ? 1'b1 : flt_r[i];
    end
  end
endmodule

// File: dv/io_port_test.sv
// register-level test of the i/o port
`timescale 1ns/1ps
`include "io_port_map.svh"
module io_port_test;
  // bench state
  logic clock = 0;
  logic rst = 1;
  logic cyc = 0;
  logic stb = 0;
  logic we = 0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rd;
  logic ack, err, wake, lp = 0, gm = 0;
  logic [6:0] irq, fetch = 7'h00;
  logic [7:0] pins, alt_in, ext_en = 8'h00, ext_val = 8'h00;
  io_port_pkg::pad_drive_s pad;
  io_port_pkg::alt_ctrl_s alt_c = '0;
  int n_fail = 0;
  int num_checks = 0;
  int cycles = 0;
  always #2.5 clock = ~clock;
  io_port dut (.clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
    .wb_err_o(err), .pin_in(pins), .pad(pad), .alt(alt_c), .alt_in(alt_in),
    .vec_map({{7{3'h1}}, 3'h0}), .global_mask(gm), .vec_fetch(fetch), .low_power(lp),
    .ext_irq(irq), .wake(wake));
  pin_model pm (.clock(clock), .pad(pad), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pins));
  // verdict and end of run
  task automatic print_verdict();
    if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // compare seen against expected
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  // one classic cycle; reads compare data, all compare err
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= {24'h0, d};
    do begin
      @(posedge clock);
    end while (ack !== 1'b1 && err !== 1'b1);
    chk({err, w ? 8'h00 : rd[7:0]}, {a > 4'h5, w ? 8'h00 : d});
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clock);
  endtask
  // pins reach reads after the synchroniser
  task automatic settle();
    repeat (6) @(posedge clock);
  endtask
  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      print_verdict();
    end
  end
  initial begin
    // outside drives every pin from the start
    ext_en <= 8'hFF;
    ext_val <= 8'h5A;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    settle();
    acc(0, `OFS_DATA, 8'h5A);
    acc(0, `OFS_DIR, `RST_DIR);
    acc(0, 4'h6, 8'h00);
    acc(1, `OFS_DIR, 8'hFF);
    acc(0, `OFS_DATA, `RST_DATA);
    acc(1, `OFS_DIR, 8'h00);
    ext_val <= 8'hA5;
    // the latch is written whole, never bit by bit
    acc(1, `OFS_DATA, 8'h3C);
    settle();
    acc(0, `OFS_DATA, 8'hA5);
    chk(pad.oe, 0);
    ext_en <= 8'h0F;
    acc(1, `OFS_OPT, 8'hF0);
    settle();
    acc(0, `OFS_DATA, 8'hF5);
    acc(1, `OFS_DIR, 8'hFF);
    acc(1, `OFS_OPT, 8'hFF);
    acc(0, `OFS_DATA, 8'h3C);
    chk({pad.oe, pad.out, alt_in}, 24'hFF3C3C);
    acc(1, `OFS_OPT, 8'h00);
    chk({pad.oe, pad.out & pad.oe}, 16'hC300);
    ext_en <= 8'hFF;
    acc(1, `OFS_DIR, 8'h00);
    settle();
    acc(1, `OFS_OPT, 8'h01);
    settle();
    chk(irq, 0);
    ext_val <= 8'hA4;
    settle();
    chk(irq, 1);
    acc(0, `OFS_STATUS, 8'h01);
    lp <= 1'b1;
    gm <= 1'b1;
    @(posedge clock);
    chk({irq, wake}, 1);
    gm <= 1'b0;
    lp <= 1'b0;
    fetch <= 7'h01;
    @(posedge clock);
    fetch <= 7'h00;
    @(posedge clock);
    chk({irq, wake}, 0);
    acc(1, `OFS_EDGE, 8'h01);
    ext_val <= 8'hA5;
    settle();
    chk(irq, 1);
    acc(1, `OFS_EDGE, 8'h00);
    chk(irq, 0);
    ext_val <= 8'hA7;
    settle();
    acc(1, `OFS_IRQCFG, 8'h06);
    acc(1, `OFS_OPT, 8'h06);
    ext_val <= 8'hA5;
    settle();
    chk(irq, 7'h02);
    fetch <= 7'h02;
    @(posedge clock);
    fetch <= 7'h00;
    ext_val <= 8'hA1;
    settle();
    chk(irq, 7'h00);
    ext_val <= 8'hA7;
    settle();
    ext_val <= 8'hA3;
    settle();
    chk(irq, 7'h02);
    // a peripheral drives pin 4 high, overriding the port
    alt_c <= '{8'h10, 8'h10, 8'h00};
    @(posedge clock);
    chk({pad.oe[4], pad.out[4]}, 2'b11);
    acc(0, `OFS_DATA, 8'hB3);
    print_verdict();
  end
endmodule
